// ### rtof_defines.svh
// rtof_defines.svh: offsets, field positions and reset values of the
// receive output formatter. assumes nothing; definitions only.
`ifndef RTOF_DEFINES_SVH
`define RTOF_DEFINES_SVH

// register indices on the command port
`define RTOF_IDX_RX_CFG    1'h0
`define RTOF_IDX_LOOP_CFG  1'h1

// rx_output_config fields
`define RTOF_RXC_SINGLE    4
`define RTOF_RXC_MUTE      3
`define RTOF_RXC_OFF       2
`define RTOF_RXC_INV       1
`define RTOF_RXC_MASK      5'h1E

// loopback_rate_config fields
`define RTOF_LBC_SONET     3
`define RTOF_LBC_EURO      2
`define RTOF_LBC_LOCAL     1
`define RTOF_LBC_REMOTE    0
`define RTOF_LBC_MASK      5'h0F

// reset values
`define RTOF_REG_RESET     5'h00

`endif

// ### rtof_pkg.sv
// rtof_pkg: types shared by the receive output formatter.
// assumes rtof_defines.svh for the numbers.
package rtof_pkg;

  typedef enum logic [1:0] {
    RTOF_RATE_DS3  = 2'h0,
    RTOF_RATE_E3   = 2'h1,
    RTOF_RATE_STS1 = 2'h2
  } rtof_rate_t;

  // effective per-channel settings, one bit per feature
  typedef struct packed {
    logic single_rail;
    logic mute_los;
    logic rx_off;
    logic clk_inv;
    logic local_loop;
  } rtof_cfg_t;

  // hardware-mode pins, all asynchronous to clk
  typedef struct packed {
    logic host_mode;
    logic global_rail_format_pin;
    logic mute_on_signal_loss;
    logic receiver_shutdown;
    logic global_clock_invert_pin;
    logic local_loop_select;
    logic remote_loop_select;
    logic sonet_rate_select;
    logic european_rate_select;
  } rtof_pins_t;

endpackage : rtof_pkg

// ### rtof_sync.sv
// rtof_sync: two-flop level synchroniser, W bits wide.
// assumes each bit is a slow level; bits may land one cycle apart.
`timescale 1ns/1ps
`default_nettype none
module rtof_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rtof_sync
`default_nettype wire

// ### rtof_rst_sync.sv
// rtof_rst_sync: reset for a second clock domain.
// assumes rst_in is asynchronous; assertion is immediate, release is
// taken two edges of clk after rst_in falls.
`timescale 1ns/1ps
`default_nettype none
module rtof_rst_sync (
  // clock and incoming reset
  input  wire logic clk,
  input  wire logic rst_in,
  // local reset
  output var  logic rst_out
);
  logic hold_q;

  always_ff @(posedge clk or posedge rst_in) begin
    if (rst_in) begin
      hold_q  <= 1'b1;
      rst_out <= 1'b1;
    end else begin
      hold_q  <= 1'b0;
      rst_out <= hold_q;
    end
  end
endmodule : rtof_rst_sync
`default_nettype wire

// ### rtof_formatter.sv
// rtof_formatter: receive output stage of one line channel.
// assumes line_clk is the recovered clock (or, in analog local loop,
// the clock that the analog mux outside routes from the tx side), and
// that line pulses, tx data and los_in are all timed by line_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtof_defines.svh"

module rtof_formatter (
  // system clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // hardware-mode pins
  input  wire rtof_pkg::rtof_pins_t hw_pins,
  // command register port (clk domain)
  input  wire logic                reg_wr_en,
  input  wire logic                reg_rd_en,
  input  wire logic                reg_idx,
  input  wire logic [4:0]          reg_wdata,
  output var  logic [4:0]          reg_rdata,
  // controls to the analog front end (clk domain)
  output var  logic                rx_section_on,
  output var  logic                local_loop_active,
  output var  rtof_pkg::rtof_rate_t rate_sel,
  // link side (line_clk domain)
  input  wire logic                line_clk,
  input  wire logic                line_in_tip,
  input  wire logic                line_in_ring,
  input  wire logic                tx_pos_data_in,
  input  wire logic                tx_neg_data_in,
  input  wire logic                los_in,
  output var  logic                recv_pos_rail,
  output var  logic                recv_neg_rail,
  output var  logic                recovered_clock_out
);

  function automatic rtof_pkg::rtof_rate_t rate_of(input logic sonet,
                                                    input logic euro);
    if (euro)
      return rtof_pkg::RTOF_RATE_E3;
    else if (sonet)
      return rtof_pkg::RTOF_RATE_STS1;
    else
      return rtof_pkg::RTOF_RATE_DS3;
  endfunction : rate_of

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  rtof_pkg::rtof_pins_t pins_s;

  rtof_sync #(.W($bits(rtof_pkg::rtof_pins_t))) u_pin_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (hw_pins),
    .q   (pins_s)
  );

  //////////////////////////////////////////////////////////////////////
  // command registers
  logic [4:0] rx_cfg_q;
  logic [4:0] loop_cfg_q;
  logic       wr_rx;
  logic       wr_loop;

  assign wr_rx   = reg_wr_en && (reg_idx == `RTOF_IDX_RX_CFG);
  assign wr_loop = reg_wr_en && (reg_idx == `RTOF_IDX_LOOP_CFG);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cfg_q   <= `RTOF_REG_RESET;
      loop_cfg_q <= `RTOF_REG_RESET;
    end else begin
      if (wr_rx)
        rx_cfg_q <= reg_wdata & `RTOF_RXC_MASK;
      if (wr_loop)
        loop_cfg_q <= reg_wdata & `RTOF_LBC_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // effective settings: host bits or global pins
  logic                 host;
  rtof_pkg::rtof_cfg_t  host_cfg;
  rtof_pkg::rtof_cfg_t  pin_cfg;
  rtof_pkg::rtof_cfg_t  cfg_d;
  rtof_pkg::rtof_cfg_t  cfg_q;
  rtof_pkg::rtof_rate_t rate_d;

  assign host = pins_s.host_mode;

  assign host_cfg.single_rail = rx_cfg_q[`RTOF_RXC_SINGLE];
  assign host_cfg.mute_los    = rx_cfg_q[`RTOF_RXC_MUTE];
  assign host_cfg.rx_off      = rx_cfg_q[`RTOF_RXC_OFF];
  assign host_cfg.clk_inv     = rx_cfg_q[`RTOF_RXC_INV];
  assign host_cfg.local_loop  = loop_cfg_q[`RTOF_LBC_LOCAL]
                              & ~loop_cfg_q[`RTOF_LBC_REMOTE];

  // one pin per feature, two for local loop, shared by every channel
  assign pin_cfg.single_rail = pins_s.global_rail_format_pin;
  assign pin_cfg.mute_los    = pins_s.mute_on_signal_loss;
  assign pin_cfg.rx_off      = pins_s.receiver_shutdown;
  assign pin_cfg.clk_inv     = pins_s.global_clock_invert_pin;
  assign pin_cfg.local_loop  = pins_s.local_loop_select
                             & ~pins_s.remote_loop_select;

  assign cfg_d  = host ? host_cfg : pin_cfg;
  assign rate_d = host ? rate_of(loop_cfg_q[`RTOF_LBC_SONET],
                                 loop_cfg_q[`RTOF_LBC_EURO])
                       : rate_of(pins_s.sonet_rate_select,
                                 pins_s.european_rate_select);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q             <= '0;
      rate_sel          <= rtof_pkg::RTOF_RATE_DS3;
      rx_section_on     <= 1'b1;
      local_loop_active <= 1'b0;
    end else begin
      cfg_q             <= cfg_d;
      rate_sel          <= rate_d;
      rx_section_on     <= ~cfg_d.rx_off;
      local_loop_active <= cfg_d.local_loop;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read: in hardware mode the pin-driven settings show
  logic [4:0] rd_rx;
  logic [4:0] rd_loop;

  assign rd_rx   = host ? rx_cfg_q
                        : {cfg_q.single_rail, cfg_q.mute_los,
                           cfg_q.rx_off, cfg_q.clk_inv, 1'b0};
  assign rd_loop = host ? loop_cfg_q
                        : {1'b0, pins_s.sonet_rate_select,
                           pins_s.european_rate_select,
                           pins_s.local_loop_select,
                           pins_s.remote_loop_select};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 5'h00;
    else if (reg_rd_en)
      reg_rdata <= (reg_idx == `RTOF_IDX_RX_CFG) ? rd_rx : rd_loop;
  end

  //////////////////////////////////////////////////////////////////////
  // crossing into the line clock domain
  logic                link_rst;
  rtof_pkg::rtof_cfg_t cfg_l;

  rtof_rst_sync u_link_rst (
    .clk     (line_clk),
    .rst_in  (sys_rst),
    .rst_out (link_rst)
  );

  // settings are static levels; a bit may land one line cycle late
  rtof_sync #(.W($bits(rtof_pkg::rtof_cfg_t))) u_cfg_sync (
    .clk (line_clk),
    .rst (link_rst),
    .d   (cfg_q),
    .q   (cfg_l)
  );

  //////////////////////////////////////////////////////////////////////
  // rail formatting on line_clk
  logic src_pos;
  logic src_neg;
  logic live;
  logic pos_d;
  logic neg_d;

  // local loop drops the line and takes the encoded tx rails
  assign src_pos = cfg_l.local_loop ? tx_pos_data_in
                                    : line_in_tip;
  assign src_neg = cfg_l.local_loop ? tx_neg_data_in
                                    : line_in_ring;
  assign live    = ~cfg_l.rx_off
                 & ~(cfg_l.mute_los & los_in);
  // single rail: either polarity marks a one
  assign pos_d   = live & (cfg_l.single_rail ? (src_pos | src_neg)
                                             : src_pos);
  assign neg_d   = live & ~cfg_l.single_rail & src_neg;

  always_ff @(posedge line_clk or posedge link_rst) begin
    if (link_rst) begin
      recv_pos_rail <= 1'b0;
      recv_neg_rail <= 1'b0;
    end else begin
      recv_pos_rail <= pos_d;
      recv_neg_rail <= neg_d;
    end
  end

  // the clock cannot come from a flop at full rate, so it is the line
  // clock gated and flipped; settings change only while traffic is
  // not trusted, since a flip mid-cycle can leave a short pulse
  assign recovered_clock_out = ~cfg_l.rx_off
                             & (line_clk ^ cfg_l.clk_inv);

  //////////////////////////////////////////////////////////////////////
  // checks
  a_neg_low_single: assert property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.single_rail |=> !recv_neg_rail)
    else $error("neg rail active in single rail");

  a_pos_follows_line: assert property (
    @(posedge line_clk) disable iff (link_rst)
    (live && !cfg_l.single_rail && !cfg_l.local_loop)
    |=> recv_pos_rail == $past(line_in_tip))
    else $error("pos rail does not track positive pulses");

  a_neg_follows_line: assert property (
    @(posedge line_clk) disable iff (link_rst)
    (live && !cfg_l.single_rail && !cfg_l.local_loop)
    |=> recv_neg_rail == $past(line_in_ring))
    else $error("neg rail does not track negative pulses");

  a_single_binary: assert property (
    @(posedge line_clk) disable iff (link_rst)
    (live && cfg_l.single_rail && (src_pos || src_neg))
    |=> recv_pos_rail)
    else $error("single rail one missing");

  a_mute_on_loss: assert property (
    @(posedge line_clk) disable iff (link_rst)
    (cfg_l.mute_los && los_in) |=> !recv_pos_rail && !recv_neg_rail)
    else $error("rails active while muted");

  a_off_quiet: assert property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.rx_off [*2] |-> !recv_pos_rail && !recv_neg_rail)
    else $error("rails active with receiver off");

  a_loop_takes_tx: assert property (
    @(posedge line_clk) disable iff (link_rst)
    (cfg_l.local_loop && live && !cfg_l.single_rail)
    |=> recv_pos_rail == $past(tx_pos_data_in)
        && recv_neg_rail == $past(tx_neg_data_in))
    else $error("local loop does not take tx data");

  a_hw_format_pin: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host |=> cfg_q.single_rail == $past(pins_s.global_rail_format_pin))
    else $error("format pin not applied");

  a_host_clk_inv: assert property (
    @(posedge clk) disable iff (sys_rst)
    (wr_rx && reg_wdata[`RTOF_RXC_INV]) ##1 host |=> cfg_q.clk_inv)
    else $error("host invert bit not applied");

  a_hw_local_loop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!host && pins_s.local_loop_select && !pins_s.remote_loop_select)
    |=> local_loop_active)
    else $error("hardware local loop not selected");

  a_reset_default: assert property (
    @(posedge clk)
    $fell(sys_rst) |-> cfg_q == '0 && rx_section_on)
    else $error("settings not at default after reset");

  a_hw_clk_inv: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host |=> cfg_q.clk_inv == $past(pins_s.global_clock_invert_pin))
    else $error("invert pin not applied");

  a_hw_shutdown: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!host && pins_s.receiver_shutdown) |=> !rx_section_on)
    else $error("shutdown pin left receiver on");

  a_host_single: assert property (
    @(posedge clk) disable iff (sys_rst)
    (host && rx_cfg_q[`RTOF_RXC_SINGLE]) |=> cfg_q.single_rail)
    else $error("host single rail bit not applied");

  a_host_rx_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (host && rx_cfg_q[`RTOF_RXC_OFF]) |=> !rx_section_on)
    else $error("host off bit left receiver on");

  a_host_local_loop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (host && loop_cfg_q[`RTOF_LBC_LOCAL] && !loop_cfg_q[`RTOF_LBC_REMOTE])
    |=> local_loop_active)
    else $error("host local loop not selected");

  a_host_rate_e3: assert property (
    @(posedge clk) disable iff (sys_rst)
    (host && loop_cfg_q[`RTOF_LBC_EURO]) |=> rate_sel == rtof_pkg::RTOF_RATE_E3)
    else $error("host rate bit not applied");

  // sampled at the rise the line clock still reads low, so the output
  // clock must read as the invert setting there
  a_clock_polarity: assert property (
    @(posedge line_clk) disable iff (link_rst)
    !cfg_l.rx_off |-> recovered_clock_out == cfg_l.clk_inv)
    else $error("output clock polarity wrong");

  a_off_no_clock: assert property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.rx_off |-> !recovered_clock_out)
    else $error("output clock runs with receiver off");

  c_single_rail: cover property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.single_rail && recv_pos_rail);

  c_local_loop: cover property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.local_loop && recv_neg_rail);

  c_muted: cover property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.mute_los && los_in);

  c_clock_inverted: cover property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.clk_inv && recv_pos_rail);

  c_rx_off: cover property (
    @(posedge line_clk) disable iff (link_rst)
    cfg_l.rx_off && !cfg_l.single_rail);

endmodule : rtof_formatter
`default_nettype wire

// ### rtof_framer_model.sv
// rtof_framer_model: receiving framer beside one formatter channel.
// assumes rails are settled at each rise of the clock it is handed.
`timescale 1ns/1ps
`default_nettype none
module rtof_framer_model (
  // clock and clear
  input  wire logic       rclk,
  input  wire logic       clr,
  // rails and their counts of ones
  input  wire logic       pos,
  input  wire logic       neg,
  output var  logic [7:0] n_pos,
  output var  logic [7:0] n_neg
);
  // always the rise: with inversion this lands mid-eye
  always @(posedge rclk or posedge clr) begin
    if (clr) begin
      n_pos <= 8'h00;
      n_neg <= 8'h00;
    end else begin
      n_pos <= n_pos + {7'h00, pos};
      n_neg <= n_neg + {7'h00, neg};
    end
  end
endmodule : rtof_framer_model
`default_nettype wire

// ### testbench.sv
// testbench: self-checking bench of one receive output formatter.
// assumes a framer model counts rail ones on the output clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 clk, sys_rst, line_clk, clr, wr, rd, idx, on, lla;
  logic                 tip, ring, txp, txn, los, pos, neg, rco;
  logic [4:0]           wd, rdat;
  logic [7:0]           np, nn;
  rtof_pkg::rtof_pins_t hw;
  rtof_pkg::rtof_rate_t rate;
  int                   n_errors, n_checks;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // link clock unrelated in phase to clk
  initial begin
    line_clk = 1'b0;
    #37;
    forever #80 line_clk = ~line_clk;
  end

  rtof_formatter u_rtof_formatter (.clk(clk), .sys_rst(sys_rst), .hw_pins(hw),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_idx(idx), .reg_wdata(wd), .reg_rdata(rdat),
    .rx_section_on(on), .local_loop_active(lla), .rate_sel(rate), .line_clk(line_clk),
    .line_in_tip(tip), .line_in_ring(ring), .tx_pos_data_in(txp), .tx_neg_data_in(txn),
    .los_in(los), .recv_pos_rail(pos), .recv_neg_rail(neg), .recovered_clock_out(rco));
  rtof_framer_model u_rtof_framer_model (.rclk(rco), .clr(clr), .pos(pos), .neg(neg),
    .n_pos(np), .n_neg(nn));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic i, input logic [4:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rd_chk(input logic i, input logic [4:0] exp);
    @(negedge clk);
    rd = 1'b1;
    idx = i;
    @(negedge clk);
    rd = 1'b0;
    chk("reg_rdata", {3'h0, exp}, {3'h0, rdat});
  endtask : rd_chk
  // config crosses to the link side in a few line cycles
  task automatic settle;
    repeat (5) @(negedge line_clk);
  endtask : settle
  // v is {tip, ring, tx pos, tx neg} for one line cycle
  task automatic pulse_chk(input logic [3:0] v, input logic [7:0] ep, input logic [7:0] en);
    @(negedge line_clk);
    clr = 1'b1;
    {tip, ring, txp, txn} = v;
    #1 clr = 1'b0;
    @(negedge line_clk);
    {tip, ring, txp, txn} = 4'h0;
    repeat (4) @(negedge line_clk);
    chk("pos ones", ep, np);
    chk("neg ones", en, nn);
  endtask : pulse_chk
  task automatic clk_chk(input logic e);
    @(posedge line_clk);
    #1;
    chk("recovered_clock_out", {7'h00, e}, {7'h00, rco});
  endtask : clk_chk
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////
  task automatic t_host_format;
    wreg(1'h0, 5'h11);
    rd_chk(1'h0, 5'h10);
    settle();
    pulse_chk(4'h8, 8'h01, 8'h00);
    pulse_chk(4'h4, 8'h01, 8'h00);
    wreg(1'h0, 5'h02);
    settle();
    clk_chk(1'b0);
    pulse_chk(4'h8, 8'h01, 8'h00);
    wreg(1'h0, 5'h04);
    settle();
    chk("rx_section_on", 8'h00, {7'h00, on});
    pulse_chk(4'h8, 8'h00, 8'h00);
    wreg(1'h0, 5'h08);
    los = 1'b1;
    settle();
    pulse_chk(4'h8, 8'h00, 8'h00);
    los = 1'b0;
    settle();
    pulse_chk(4'h4, 8'h00, 8'h01);
    chk("rx_section_on", 8'h01, {7'h00, on});
  endtask : t_host_format
  task automatic t_loop;
    wreg(1'h1, 5'h1A);
    rd_chk(1'h1, 5'h0A);
    settle();
    chk("local_loop_active", 8'h01, {7'h00, lla});
    chk("rate_sel", {6'h00, rtof_pkg::RTOF_RATE_STS1}, {6'h00, rate});
    pulse_chk(4'h8, 8'h00, 8'h00);
    pulse_chk(4'h2, 8'h01, 8'h00);
    pulse_chk(4'h1, 8'h00, 8'h01);
    wreg(1'h1, 5'h07);
    settle();
    chk("local_loop_active", 8'h00, {7'h00, lla});
    chk("rate_sel", {6'h00, rtof_pkg::RTOF_RATE_E3}, {6'h00, rate});
    wreg(1'h1, 5'h00);
  endtask : t_loop
  task automatic t_pins;
    hw.host_mode = 1'b0;
    hw.global_rail_format_pin = 1'b1;
    hw.global_clock_invert_pin = 1'b1;
    settle();
    rd_chk(1'h0, 5'h12);
    clk_chk(1'b0);
    pulse_chk(4'h4, 8'h01, 8'h00);
    hw.global_rail_format_pin = 1'b0;
    hw.global_clock_invert_pin = 1'b0;
    hw.receiver_shutdown = 1'b1;
    settle();
    chk("rx_section_on", 8'h00, {7'h00, on});
    pulse_chk(4'h4, 8'h00, 8'h00);
    hw.receiver_shutdown = 1'b0;
    hw.local_loop_select = 1'b1;
    settle();
    chk("local_loop_active", 8'h01, {7'h00, lla});
    hw.remote_loop_select = 1'b1;
    settle();
    chk("local_loop_active", 8'h00, {7'h00, lla});
  endtask : t_pins
  // reset in mid-run must bring back every default from a busy setting
  task automatic t_reset;
    hw = '0;
    hw.host_mode = 1'b1;
    settle();
    wreg(1'h0, 5'h16);
    wreg(1'h1, 5'h0A);
    settle();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(1'h0, 5'h00);
    rd_chk(1'h1, 5'h00);
    settle();
    chk("rx_section_on", 8'h01, {7'h00, on});
    chk("local_loop_active", 8'h00, {7'h00, lla});
    clk_chk(1'b1);
    pulse_chk(4'h4, 8'h00, 8'h01);
  endtask : t_reset

  ////////////////////////////////////////////////////////////
  initial begin
    // a clean rising step, so every async reset fed from sys_rst sees an edge at start
    sys_rst = 1'b0;
    hw = '0;
    hw.host_mode = 1'b1;
    {wr, rd, idx, wd, tip, ring, txp, txn, los, clr} = '0;
    n_errors = 0;
    n_checks = 0;
    #1;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(1'h0, 5'h00);
    rd_chk(1'h1, 5'h00);
    chk("rx_section_on", 8'h01, {7'h00, on});
    chk("local_loop_active", 8'h00, {7'h00, lla});
    settle();
    clk_chk(1'b1);
    pulse_chk(4'h8, 8'h01, 8'h00);
    pulse_chk(4'h4, 8'h00, 8'h01);
    pulse_chk(4'hC, 8'h01, 8'h01);
    t_host_format();
    t_loop();
    t_pins();
    t_reset();
    close_out();
  end
  // a hang anywhere ends the run as a failure
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
